// *** rtl/ssns_edge.sv ***
`timescale 1ns/1ps
// ==========================================================
// falling-edge detector for a live status level
module ssns_edge (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // level in
  input wire logic level_i,
  // results
  output logic level_q_o,
  output logic fall_o
);
  // registered copy of the level, starts as not good
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      level_q_o <= 1'b0;
    end else begin
      level_q_o <= level_i;
    end
  end

  // loss pulses when the level drops
  always_comb begin
    fall_o = level_q_o && !level_i;
  end
endmodule : ssns_edge

// *** rtl/ssns_osc.sv ***
`timescale 1ns/1ps
// ==========================================================
// phase accumulator that strobes on each carry out of the top bit
module ssns_osc #(
  parameter int WIDTH = ssns_pkg::OSC_WIDTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic hold_i,
  input wire logic [WIDTH-1:0] incr_i,
  // result
  output logic strobe_o
);
  logic [WIDTH-1:0] phase; // running phase
  logic [WIDTH:0] next_sum; // sum with carry

  // ========================================================
  // accumulate
  always_comb begin
    next_sum = {1'b0, phase} + {1'b0, incr_i};
  end

  // phase register, held at zero on request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase <= '0;
    end else if (hold_i) begin
      phase <= '0;
    end else begin
      phase <= next_sum[WIDTH-1:0];
    end
  end

  // one-cycle strobe on carry out
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      strobe_o <= 1'b0;
    end else begin
      strobe_o <= !hold_i && next_sum[WIDTH];
    end
  end
endmodule : ssns_osc

// *** rtl/ssns_pkg.sv ***
// ==========================================================
// shared constants for the strobe oscillators and serdes status
package ssns_pkg;
  // ========================================================
  // register byte addresses
  localparam logic [15:0] ADDR_SERDES_CFG = 16'hf954;
  localparam logic [15:0] ADDR_OSC1_LO = 16'hf958;
  localparam logic [15:0] ADDR_OSC1_HI = 16'hf95c;
  localparam logic [15:0] ADDR_OSC2_LO = 16'hf960;
  localparam logic [15:0] ADDR_OSC2_HI = 16'hf964;
  localparam logic [15:0] ADDR_OSC_CTRL = 16'hf968;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hf96c;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hf970;
  // ========================================================
  // field positions
  localparam int BIT_UNLOCK = 6;
  localparam int BIT_LOST_ALIGN = 5;
  localparam int BIT_LOCK = 4;
  localparam int BIT_SYNC = 3;
  localparam int BIT_OFF = 0;
  localparam int BIT_HOLD = 0;
  localparam int BIT_PICK = 1;
  localparam int BIT_RATE_LO = 2;
  localparam int BIT_RATE_HI = 3;
  localparam int IRQ_UNLOCK = 0;
  localparam int IRQ_LOST_ALIGN = 1;
  // ========================================================
  // reset values
  localparam logic [15:0] RST_SERDES_CFG = 16'h0000;
  localparam logic [15:0] RST_OSC1_LO = 16'hd098;
  localparam logic [7:0] RST_OSC1_HI = 8'h5e;
  localparam logic [15:0] RST_OSC2_LO = 16'h097c;
  localparam logic [7:0] RST_OSC2_HI = 8'hed;
  localparam logic [3:0] RST_OSC_CTRL = 4'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  // ========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ========================================================
  // oscillator geometry
  localparam int OSC_WIDTH = 24;
endpackage : ssns_pkg

// *** rtl/ssns_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// serdes status, macro disable and strobe oscillators
module ssns_top #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  // axi4-lite write data
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // axi4-lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  // axi4-lite read data
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // serdes status from the pll and media attachment
  input wire logic PLL_LOCKED_I,
  input wire logic PMA_SYNCED_I,
  // controls toward the serdes macro
  output logic SERDES_MACRO_OFF_O,
  output logic [1:0] SERIAL_RATE_SELECT_O,
  // media interface clock strobe
  output logic LINK_STROBE_O,
  // interrupt
  output logic IRQ_O
);
  // ========================================================
  // declarations
  logic [15:0] osc1_increment_low_field; // oscillator one low bits
  logic [7:0] osc1_increment_high_field; // oscillator one high bits
  logic [15:0] osc2_increment_low_field; // oscillator two low bits
  logic [7:0] osc2_increment_high_field; // oscillator two high bits
  logic serdes_macro_off; // macro disable level
  logic hold_counters_zero; // hold both accumulators at zero
  logic strobe_source_pick; // 0 first, 1 second oscillator
  logic [1:0] serial_rate_select; // link rate code
  logic lost_lock_sticky; // sticky pll loss
  logic lost_alignment_sticky; // sticky sync loss
  logic [1:0] irq_mask; // interrupt enables
  logic lock_q; // registered live lock
  logic sync_q; // registered live sync
  logic lock_fall; // lock loss event
  logic sync_fall; // sync loss event
  logic strobe1; // first oscillator strobe
  logic strobe2; // second oscillator strobe
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [ADDR_W-1:0] aw_addr; // captured write address
  logic [31:0] w_data; // captured write data
  logic [3:0] w_strb; // captured byte enables
  logic do_write; // both halves present
  logic wr_hit; // write address mapped
  logic [31:0] rd_word; // decoded read word
  logic rd_hit; // read address mapped

  // ========================================================
  // address decode, used for reads and writes
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[15:0] == ssns_pkg::ADDR_SERDES_CFG) ||
                (a[15:0] == ssns_pkg::ADDR_OSC1_LO) ||
                (a[15:0] == ssns_pkg::ADDR_OSC1_HI) ||
                (a[15:0] == ssns_pkg::ADDR_OSC2_LO) ||
                (a[15:0] == ssns_pkg::ADDR_OSC2_HI) ||
                (a[15:0] == ssns_pkg::ADDR_OSC_CTRL) ||
                (a[15:0] == ssns_pkg::ADDR_IRQ_STAT) ||
                (a[15:0] == ssns_pkg::ADDR_IRQ_MASK);
  endfunction : is_mapped

  // ========================================================
  // status edge detectors
  ssns_edge u_lock_edge (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .level_i(PLL_LOCKED_I),
    .level_q_o(lock_q),
    .fall_o(lock_fall)
  );

  ssns_edge u_sync_edge (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .level_i(PMA_SYNCED_I),
    .level_q_o(sync_q),
    .fall_o(sync_fall)
  );

  // ========================================================
  // oscillators
  ssns_osc #(.WIDTH(ssns_pkg::OSC_WIDTH)) u_osc1 (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .hold_i(hold_counters_zero),
    .incr_i({osc1_increment_high_field,
             osc1_increment_low_field}),
    .strobe_o(strobe1)
  );

  ssns_osc #(.WIDTH(ssns_pkg::OSC_WIDTH)) u_osc2 (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .hold_i(hold_counters_zero),
    .incr_i({osc2_increment_high_field,
             osc2_increment_low_field}),
    .strobe_o(strobe2)
  );

  // ========================================================
  // write channel capture, address and data in either order
  always_comb begin
    do_write = aw_held && w_held && !BVALID_O;
    wr_hit = is_mapped(aw_addr);
  end

  // write address holding
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR_I;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (WVALID_I && WREADY_O) begin
      w_held <= 1'b1;
      w_data <= WDATA_I;
      w_strb <= WSTRB_I;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // readies drop while a half is held
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
    end else begin
      AWREADY_O <= !aw_held && !(AWVALID_I && AWREADY_O);
      WREADY_O <= !w_held && !(WVALID_I && WREADY_O);
    end
  end

  // write response
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= ssns_pkg::RESP_OKAY;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O <= wr_hit ? ssns_pkg::RESP_OKAY : ssns_pkg::RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // ========================================================
  // increment registers, byte lanes honoured
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      osc1_increment_low_field <= ssns_pkg::RST_OSC1_LO;
      osc1_increment_high_field <= ssns_pkg::RST_OSC1_HI;
      osc2_increment_low_field <= ssns_pkg::RST_OSC2_LO;
      osc2_increment_high_field <= ssns_pkg::RST_OSC2_HI;
    end else if (do_write) begin
      unique case (aw_addr[15:0])
        ssns_pkg::ADDR_OSC1_LO: begin
          if (w_strb[0]) osc1_increment_low_field[7:0] <= w_data[7:0];
          if (w_strb[1]) osc1_increment_low_field[15:8] <= w_data[15:8];
        end
        ssns_pkg::ADDR_OSC1_HI: begin
          if (w_strb[0]) osc1_increment_high_field <= w_data[7:0];
        end
        ssns_pkg::ADDR_OSC2_LO: begin
          if (w_strb[0]) osc2_increment_low_field[7:0] <= w_data[7:0];
          if (w_strb[1]) osc2_increment_low_field[15:8] <= w_data[15:8];
        end
        ssns_pkg::ADDR_OSC2_HI: begin
          if (w_strb[0]) osc2_increment_high_field <= w_data[7:0];
        end
        default: begin
          // other addresses leave the increments alone
        end
      endcase
    end
  end

  // ========================================================
  // control bits: disable, hold, pick, rate, mask
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      serdes_macro_off <= ssns_pkg::RST_SERDES_CFG[ssns_pkg::BIT_OFF];
      hold_counters_zero <= ssns_pkg::RST_OSC_CTRL[ssns_pkg::BIT_HOLD];
      strobe_source_pick <= ssns_pkg::RST_OSC_CTRL[ssns_pkg::BIT_PICK];
      serial_rate_select <= ssns_pkg::RST_OSC_CTRL[3:2];
      irq_mask <= ssns_pkg::RST_IRQ_MASK;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr[15:0] == ssns_pkg::ADDR_SERDES_CFG) begin
        serdes_macro_off <= w_data[ssns_pkg::BIT_OFF];
      end
      if (aw_addr[15:0] == ssns_pkg::ADDR_OSC_CTRL) begin
        hold_counters_zero <= w_data[ssns_pkg::BIT_HOLD];
        strobe_source_pick <= w_data[ssns_pkg::BIT_PICK];
        serial_rate_select <=
          w_data[ssns_pkg::BIT_RATE_HI:ssns_pkg::BIT_RATE_LO];
      end
      if (aw_addr[15:0] == ssns_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // ========================================================
  // sticky loss flags, set wins over write-one clear
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      lost_lock_sticky <= 1'b0;
      lost_alignment_sticky <= 1'b0;
    end else begin
      if (lock_fall) begin
        lost_lock_sticky <= 1'b1;
      end else if (do_write && w_strb[0] &&
                   ((aw_addr[15:0] == ssns_pkg::ADDR_SERDES_CFG &&
                     w_data[ssns_pkg::BIT_UNLOCK]) ||
                    (aw_addr[15:0] == ssns_pkg::ADDR_IRQ_STAT &&
                     w_data[ssns_pkg::IRQ_UNLOCK]))) begin
        lost_lock_sticky <= 1'b0;
      end
      if (sync_fall) begin
        lost_alignment_sticky <= 1'b1;
      end else if (do_write && w_strb[0] &&
                   ((aw_addr[15:0] == ssns_pkg::ADDR_SERDES_CFG &&
                     w_data[ssns_pkg::BIT_LOST_ALIGN]) ||
                    (aw_addr[15:0] == ssns_pkg::ADDR_IRQ_STAT &&
                     w_data[ssns_pkg::IRQ_LOST_ALIGN]))) begin
        lost_alignment_sticky <= 1'b0;
      end
    end
  end

  // ========================================================
  // read decode
  always_comb begin
    rd_word = '0;
    rd_hit = is_mapped(ARADDR_I);
    unique case (ARADDR_I[15:0])
      ssns_pkg::ADDR_SERDES_CFG: begin
        rd_word[ssns_pkg::BIT_UNLOCK] = lost_lock_sticky;
        rd_word[ssns_pkg::BIT_LOST_ALIGN] = lost_alignment_sticky;
        rd_word[ssns_pkg::BIT_LOCK] = lock_q;
        rd_word[ssns_pkg::BIT_SYNC] = sync_q;
        rd_word[ssns_pkg::BIT_OFF] = serdes_macro_off;
      end
      ssns_pkg::ADDR_OSC1_LO: rd_word[15:0] = osc1_increment_low_field;
      ssns_pkg::ADDR_OSC1_HI: rd_word[7:0] = osc1_increment_high_field;
      ssns_pkg::ADDR_OSC2_LO: rd_word[15:0] = osc2_increment_low_field;
      ssns_pkg::ADDR_OSC2_HI: rd_word[7:0] = osc2_increment_high_field;
      ssns_pkg::ADDR_OSC_CTRL: begin
        rd_word[3:0] = {serial_rate_select, strobe_source_pick,
                        hold_counters_zero};
      end
      ssns_pkg::ADDR_IRQ_STAT: begin
        rd_word[1:0] = {lost_alignment_sticky, lost_lock_sticky};
      end
      ssns_pkg::ADDR_IRQ_MASK: rd_word[1:0] = irq_mask;
      default: rd_word = '0; // unmapped reads zero
    endcase
  end

  // read channel, one read at a time
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= ssns_pkg::RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rd_word;
      RRESP_O <= rd_hit ? ssns_pkg::RESP_OKAY : ssns_pkg::RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end else if (!RVALID_O) begin
      ARREADY_O <= 1'b1;
    end
  end

  // ========================================================
  // outputs toward the macro and link
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      SERDES_MACRO_OFF_O <= 1'b0;
      SERIAL_RATE_SELECT_O <= '0;
      LINK_STROBE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      SERDES_MACRO_OFF_O <= serdes_macro_off;
      SERIAL_RATE_SELECT_O <= serial_rate_select;
      LINK_STROBE_O <= strobe_source_pick ? strobe2 : strobe1;
      IRQ_O <= |({lost_alignment_sticky, lost_lock_sticky} & irq_mask);
    end
  end
endmodule : ssns_top

// *** tb/ssns_assertions.sv ***
`timescale 1ns/1ps
// ==========================================================
// port-level checks of bus answers, status and controls
module ssns_checker #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  // register bus
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  // serdes side
  input wire logic PLL_LOCKED_I,
  input wire logic PMA_SYNCED_I,
  input wire logic SERDES_MACRO_OFF_O,
  input wire logic [1:0] SERIAL_RATE_SELECT_O,
  input wire logic IRQ_O
);
  logic [3:0] quiet; // cycles since a loss level or a write answer
  logic mapped; // read address hits a register
  assign mapped = ARADDR_I inside {ssns_pkg::ADDR_SERDES_CFG,
    ssns_pkg::ADDR_OSC1_LO, ssns_pkg::ADDR_OSC1_HI, ssns_pkg::ADDR_OSC2_LO,
    ssns_pkg::ADDR_OSC2_HI, ssns_pkg::ADDR_OSC_CTRL,
    ssns_pkg::ADDR_IRQ_STAT, ssns_pkg::ADDR_IRQ_MASK};
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ========================================================
  // quiet counter, saturating
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I || !PLL_LOCKED_I || !PMA_SYNCED_I || BVALID_O) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  // ========================================================
  // bus handshakes
  sequence wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence rd_taken;
    ARVALID_I && ARREADY_O;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 BVALID_O)
    else $error("write response missing");
  a_read_answer: assert property (rd_taken |=> RVALID_O)
    else $error("read response missing");
  a_unmapped_read: assert property (
    rd_taken and !mapped |=> RRESP_O == ssns_pkg::RESP_SLVERR
    && RDATA_O == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_bresp_held: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write response dropped early");
  a_rdata_held: assert property (RVALID_O && !RREADY_I |=>
    RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
    else $error("read response changed early");
  // ========================================================
  // status, interrupt and controls
  a_irq_rise: assert property ($rose(IRQ_O) |-> quiet <= 4'h4)
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(IRQ_O) && $past(RST_B_I)
    |-> $past(BVALID_O) || $past(BVALID_O, 2))
    else $error("interrupt fell without a write");
  a_off_change: assert property ($changed(SERDES_MACRO_OFF_O)
    && $past(RST_B_I) |-> $past(BVALID_O))
    else $error("macro disable moved without a write");
  a_rate_change: assert property ($changed(SERIAL_RATE_SELECT_O)
    && $past(RST_B_I) |-> $past(BVALID_O))
    else $error("rate select moved without a write");
endmodule : ssns_checker

bind ssns_top ssns_checker #(.ADDR_W(ADDR_W)) i_ssns_checker (
  .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
  .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .PLL_LOCKED_I(PLL_LOCKED_I), .PMA_SYNCED_I(PMA_SYNCED_I),
  .SERDES_MACRO_OFF_O(SERDES_MACRO_OFF_O),
  .SERIAL_RATE_SELECT_O(SERIAL_RATE_SELECT_O), .IRQ_O(IRQ_O));

// *** tb/ssns_phy_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// serdes macro stand-in: lock and sync levels follow the disable
module ssns_phy_model #(
  parameter int LOCK_AT = 20,
  parameter int SYNC_AT = 30
) (
  // clock
  input wire logic clk_i,
  // control from the block
  input wire logic macro_off_i,
  // live status levels
  output logic locked_o,
  output logic synced_o
);
  int up_cnt = 40; // cycles since the macro was released
  // inhibited macro drops everything; relock takes a bring-up run
  always @(posedge clk_i) begin
    if (macro_off_i) begin
      up_cnt <= 0;
    end else if (up_cnt != 40) begin
      up_cnt <= up_cnt + 1;
    end
  end
  assign locked_o = (up_cnt >= LOCK_AT);
  assign synced_o = (up_cnt >= SYNC_AT);
endmodule : ssns_phy_model

// *** tb/test_sgmii_strobe_nco_status.sv ***
`timescale 1ns/1ps
// ==========================================================
// register, status, interrupt and strobe tests
module test_sgmii_strobe_nco_status;
  logic clk = 1'b0; // 200 MHz
  logic rst_b = 1'b0; // active low reset
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, locked, synced;
  logic off, strobe, irq;
  logic [1:0] bresp, rresp, rate, wresp;
  logic [31:0] rdata, got;
  int failures = 0;
  int checks_done = 0;
  int hits;
  logic [15:0] addr_tab [8] = '{16'hf954, 16'hf958, 16'hf95c, 16'hf960,
    16'hf964, 16'hf968, 16'hf96c, 16'hf970};
  logic [31:0] rst_tab [8] = '{32'h18, 32'hd098, 32'h5e, 32'h097c,
    32'hed, 32'h0, 32'h0, 32'h0};
  logic [3:0] ctl_tab [3] = '{4'h0, 4'ha, 4'hd};
  int cnt_tab [3] = '{250, 200, 0};
  always #2.5 clk = ~clk;
  // ========================================================
  // design and far side
  ssns_top i_ssns_top (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .PLL_LOCKED_I(locked), .PMA_SYNCED_I(synced),
    .SERDES_MACRO_OFF_O(off), .SERIAL_RATE_SELECT_O(rate),
    .LINK_STROBE_O(strobe), .IRQ_O(irq));
  ssns_phy_model i_ssns_phy_model (
    .clk_i(clk), .macro_off_i(off), .locked_o(locked), .synced_o(synced));
  // ========================================================
  // verdict and run end
  task automatic stop_test;
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bounded wait ran out
  task automatic hang(input int n);
    if (n >= 100) begin
      chk(32'hdead, 32'h0);
      stop_test();
    end
  endtask : hang
  // bus write: address and data together, wait for answer
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bvalid && n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    wresp = bresp;
    bready <= 1'b0;
    hang(n);
    @(posedge clk);
  endtask : wr
  // bus read: wait for answer, return data and code
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rvalid && n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    hang(n);
    @(posedge clk);
  endtask : rd
  // read and compare data with an okay code
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    logic [1:0] r;
    rd(a, got, r);
    chk(got, e);
    chk({30'h0, r}, {30'h0, ssns_pkg::RESP_OKAY});
  endtask : rchk
  // ========================================================
  // main sequence
  initial begin
    logic [1:0] r;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    // reset values, live lock and sync high
    for (int i = 0; i < 8; i++) begin
      rchk(addr_tab[i], rst_tab[i]);
    end
    // unmapped read and write are refused
    rd(16'hf974, got, r);
    chk({30'h0, r}, {30'h0, ssns_pkg::RESP_SLVERR});
    chk(got, 32'h0);
    wr(16'hf974, 32'h1);
    chk({30'h0, wresp}, {30'h0, ssns_pkg::RESP_SLVERR});
    // split increments keep only their fields
    wr(16'hf958, 32'hffff_1234);
    chk({30'h0, wresp}, {30'h0, ssns_pkg::RESP_OKAY});
    rchk(16'hf958, 32'h1234);
    wr(16'hf964, 32'hffff_ffff);
    rchk(16'hf964, 32'h00ff);
    // oscillators: 125 MHz of 200 MHz, and one half rate
    wr(16'hf958, 32'h0);
    wr(16'hf95c, 32'ha0);
    wr(16'hf960, 32'h0);
    wr(16'hf964, 32'h80);
    for (int i = 0; i < 3; i++) begin
      wr(16'hf968, {28'h0, ctl_tab[i]});
      repeat (6) @(posedge clk);
      chk({30'h0, rate}, {30'h0, ctl_tab[i][3:2]});
      hits = 0;
      repeat (400) begin
        @(posedge clk);
        hits += int'(strobe === 1'b1);
      end
      chk(hits, cnt_tab[i]);
    end
    // disable drops lock and sync, sticky flags set
    wr(16'hf954, 32'h1);
    repeat (5) @(posedge clk);
    chk({31'h0, off}, 32'h1);
    rchk(16'hf954, 32'h61);
    chk({31'h0, irq}, 32'h0);
    wr(16'hf970, 32'h3);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(16'hf96c, 32'h3);
    // release, relock; flags stay until written
    wr(16'hf954, 32'h0);
    repeat (45) @(posedge clk);
    chk({31'h0, off}, 32'h0);
    rchk(16'hf954, 32'h78);
    wr(16'hf96c, 32'h1);
    rchk(16'hf954, 32'h38);
    chk({31'h0, irq}, 32'h1);
    wr(16'hf954, 32'h20);
    rchk(16'hf954, 32'h18);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule : test_sgmii_strobe_nco_status
